// ---- rtl/synth_prog_params.svh ----
// Offsets, field positions, reset values and counts of the serial latch
`ifndef SYNTH_PROG_PARAMS_SVH
`define SYNTH_PROG_PARAMS_SVH

// APB register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_RD_SEL 8'h08
`define ADDR_RD_DATA 8'h0C
`define ADDR_CAL 8'h10
`define CTRL_RESET 32'h0000_0001
`define ERR_DATA 32'h0000_0000

// Latch bank
`define NUM_LATCHES 14
`define LAST_INDEX 4'hD
`define WORD_BITS 32

// Synchronised pin indices
`define NUM_PINS 6
`define PIN_SCLK 0
`define PIN_SDATA 1
`define PIN_LOAD 2
`define PIN_REF 3
`define PIN_LOCK 4
`define PIN_VHI 5

// Register 0 fields
`define INT_MSB 19
`define INT_LSB 4
`define AUTOCAL_BIT 21
// Register 1 field
`define MAIN_FRACTION_NUMERATOR_MSB 27
`define MAIN_FRACTION_NUMERATOR_LSB 4
// Registers 2 and 13: auxiliary fraction and modulus halves
`define AUX_FRACTION_NUMERATOR_MSB 31
`define AUX_FRACTION_NUMERATOR_LSB 18
`define AUX_MODULUS_MSB 17
`define AUX_MODULUS_LSB 4
// Register 4 fields
`define RCNT_MSB 24
`define RCNT_LSB 15
`define DBL_BIT 26
`define HALF_BIT 25
`define CP_MSB 13
`define CP_LSB 10
`define DBB_BIT 14
`define MUX_MSB 29
`define MUX_LSB 27
// Register 6 fields
`define ODIV_MSB 23
`define ODIV_LSB 21
`define PWR_MSB 2
`define PWR_LSB 1
`define MUTE_UNTIL_LOCK_BIT 11

// Band search width: 2 core bits plus 8 band bits
`define SAR_BITS 10
`define SAR_START 10'h200

`endif

// ---- rtl/synth_prog_pkg.sv ----
// Types shared by the serial latch and its band selector
package synth_prog_pkg;

  // Band search state
  typedef enum logic {CAL_IDLE, CAL_TRIAL} cal_state_t;

  // Oscillator core and band chosen by calibration
  typedef struct packed {
    logic [1:0] core;
    logic [7:0] band;
  } cal_code_t;

endpackage

// ---- rtl/band_select.sv ----
// Successive approximation search for oscillator core and band
`timescale 1ns/10ps
`default_nettype none
`include "synth_prog_params.svh"
module band_select
  import synth_prog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic tick,
  input wire logic vco_high,
  output logic busy,
  output cal_code_t code
);

  cal_state_t state_r; // Search state
  logic [`SAR_BITS-1:0] trial_r; // Trial code
  logic [3:0] bit_r; // Bit under trial

  // Search steps once per reference tick, MSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CAL_IDLE;
      trial_r <= `SAR_START;
      bit_r <= 4'h9;
    end else if (start) begin
      // Restart wins over a search in flight
      state_r <= CAL_TRIAL;
      trial_r <= `SAR_START;
      bit_r <= 4'h9;
    end else if (state_r == CAL_TRIAL && tick) begin
      // Too fast: drop the bit under trial
      if (vco_high) begin
        trial_r[bit_r] <= 1'b0;
      end
      if (bit_r == 4'h0) begin
        state_r <= CAL_IDLE;
      end else begin
        trial_r[bit_r - 4'h1] <= 1'b1;
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  // Busy and code straight from flops
  always_comb begin
    busy = (state_r == CAL_TRIAL);
    code = trial_r;
  end

  AST_CAL_START: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> busy && trial_r == `SAR_START)
    else $error("band search did not start");
  AST_CAL_END: assert property (@(posedge pclk) disable iff (!presetn)
    busy && tick && !start && bit_r == 4'h0 |=> !busy)
    else $error("band search did not finish");

endmodule // band_select
`default_nettype wire

// ---- rtl/synth_serial_program_latch.sv ----
// Three-wire program latch bank of the synthesizer, with APB view
// Functional notes
// - Shift one bit per clock rise, MSB first
// - Load strobe rise copies word into latch
// - Destination select sits in bits 3..0
// - Select code n loads latch n, 0..13
// - Buffered settings apply on next register-0 load
// - Output divider buffered only if reg4 bit14
// - Integer mode when both numerators are zero
// - Reference divider ratio 1..1023, ten bits
// - Register-0 load with autocal starts band search
// - Search clocked by reference divider; loop resumes
// - Three-bit select picks test mux signal
// - Register 6 bits 2..1 set output power
// - Mute-until-lock holds output off until lock
// - Both moduli form one 52-bit fraction; code forms it from the numerators, the moduli give 28-bit aux_modulus
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "synth_prog_params.svh"
module synth_serial_program_latch
  import synth_prog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic ref_in,
  input wire logic lock_detect,
  input wire logic vco_high,
  output logic [15:0] int_value,
  output logic [51:0] fine_fraction,
  output logic [27:0] aux_modulus,
  output logic int_mode,
  output logic [9:0] ref_count,
  output logic ref_doubler,
  output logic ref_half_divide,
  output logic [3:0] cp_current,
  output logic [2:0] out_div_sel,
  output logic [1:0] rf_power_level,
  output logic rf_out_enable,
  output logic test_mux_pin,
  output cal_code_t cal_code,
  output logic cal_busy,
  output logic loop_enable,
  output logic pfd_tick
);

  // Pin synchronisers
  logic [`NUM_PINS-1:0] pin_raw; // Raw pin levels
  logic [2:0] sync_r [0:`NUM_PINS-1]; // Three-stage chains
  logic [`NUM_PINS-1:0] pin_q_r; // Agreed level
  logic [`NUM_PINS-1:0] pin_rise; // Agreed rising edge

  // Serial and latch state
  logic [`WORD_BITS-1:0] shift_r; // Input shift register
  logic [`WORD_BITS-1:0] latch_r [0:`NUM_LATCHES-1]; // Latch bank
  logic [3:0] dest_select_bits; // Destination field
  logic latch_we; // Accepted load
  logic reg0_load; // Register-0 load
  logic port_en_r; // Serial port enable
  logic [3:0] rd_sel_r; // Readback index

  // Band selector wiring
  logic cal_start; // Search trigger
  logic sel_busy; // Selector busy
  cal_code_t sel_code; // Selector result

  // APB decode
  logic apb_setup; // Setup phase seen
  logic apb_wr; // Write takes effect
  logic [31:0] rd_nxt; // Read value
  logic err_nxt; // Unmapped address

  assign pin_raw = {vco_high, lock_detect, ref_in, load_strobe,
                    ser_data, ser_clk};

  // Each pin: three flops, level moves when stages two and three agree
  genvar g;
  for (g = 0; g < `NUM_PINS; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_r[g] <= 3'h0;
        pin_q_r[g] <= 1'b0;
      end else begin
        sync_r[g] <= {sync_r[g][1:0], pin_raw[g]};
        if (sync_r[g][1] == sync_r[g][2]) begin
          pin_q_r[g] <= sync_r[g][2];
        end
      end
    end
    assign pin_rise[g] = sync_r[g][1] & sync_r[g][2] & ~pin_q_r[g];
  end

  // Destination decode from the low nibble
  assign dest_select_bits = shift_r[3:0];
  // Codes above 13 fall through with no latch touched
  assign latch_we = pin_rise[`PIN_LOAD] &&
                    dest_select_bits <= `LAST_INDEX;
  assign reg0_load = latch_we && dest_select_bits == 4'h0;
  // Autocal request rides on the word being loaded
  assign cal_start = reg0_load && shift_r[`AUTOCAL_BIT];

  // Shift register, MSB first; a strobe does not clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 32'h0000_0000;
    end else if (port_en_r && pin_rise[`PIN_SCLK]) begin
      shift_r <= {shift_r[30:0], pin_q_r[`PIN_SDATA]};
    end
  end

  // Latch bank; word taken as it stands at strobe rise
  for (g = 0; g < `NUM_LATCHES; g++) begin : g_latch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latch_r[g] <= 32'h0000_0000;
      end else if (latch_we && dest_select_bits == 4'(g)) begin
        latch_r[g] <= shift_r;
      end
    end
  end

  // Immediate register-0 field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_value <= 16'h0000;
    end else if (reg0_load) begin
      int_value <= shift_r[`INT_MSB:`INT_LSB];
    end
  end

  // Double-buffered settings move only on a register-0 load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_fraction <= 52'h0_0000_0000_0000;
      aux_modulus <= 28'h000_0000;
      ref_count <= 10'h001;
      ref_doubler <= 1'b0;
      ref_half_divide <= 1'b0;
      cp_current <= 4'h0;
    end else if (reg0_load) begin
      // Main numerator on top, auxiliary numerator below
      fine_fraction <= {latch_r[1][`MAIN_FRACTION_NUMERATOR_MSB:`MAIN_FRACTION_NUMERATOR_LSB],
                        latch_r[13][`AUX_FRACTION_NUMERATOR_MSB:`AUX_FRACTION_NUMERATOR_LSB],
                        latch_r[2][`AUX_FRACTION_NUMERATOR_MSB:`AUX_FRACTION_NUMERATOR_LSB]};
      aux_modulus <= {latch_r[13][`AUX_MODULUS_MSB:`AUX_MODULUS_LSB],
                      latch_r[2][`AUX_MODULUS_MSB:`AUX_MODULUS_LSB]};
      ref_count <= latch_r[4][`RCNT_MSB:`RCNT_LSB];
      ref_doubler <= latch_r[4][`DBL_BIT];
      ref_half_divide <= latch_r[4][`HALF_BIT];
      cp_current <= latch_r[4][`CP_MSB:`CP_LSB];
    end
  end

  // Output divider: immediate, or held for register 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_div_sel <= 3'h0;
    end else if (latch_we && dest_select_bits == 4'h6 &&
                 !latch_r[4][`DBB_BIT]) begin
      out_div_sel <= shift_r[`ODIV_MSB:`ODIV_LSB];
    end else if (reg0_load && latch_r[4][`DBB_BIT]) begin
      out_div_sel <= latch_r[6][`ODIV_MSB:`ODIV_LSB];
    end
  end

  // Integer mode follows the applied numerators a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mode <= 1'b1;
    end else begin
      int_mode <= (fine_fraction == 52'h0_0000_0000_0000);
    end
  end

  // Output stage: power level and mute until lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_power_level <= 2'h0;
      rf_out_enable <= 1'b0;
    end else begin
      rf_power_level <= latch_r[6][`PWR_MSB:`PWR_LSB];
      rf_out_enable <= !(latch_r[6][`MUTE_UNTIL_LOCK_BIT] &&
                         !pin_q_r[`PIN_LOCK]);
    end
  end

  // Reference divider: one tick per ref_count reference rises
  logic [9:0] ref_cnt_r; // Reference rise counter
  logic [9:0] ref_last; // Terminal count
  // Zero is outside the allowed range; treat it as divide by one
  assign ref_last = (ref_count == 10'h000) ? 10'h000 :
                    ref_count - 10'h001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= 10'h000;
      pfd_tick <= 1'b0;
    end else if (pin_rise[`PIN_REF]) begin
      if (ref_cnt_r >= ref_last) begin
        ref_cnt_r <= 10'h000;
        pfd_tick <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 10'h001;
        pfd_tick <= 1'b0;
      end
    end else begin
      pfd_tick <= 1'b0;
    end
  end

  // Band search runs on the divided reference
  band_select u_band (
    .pclk(pclk),
    .presetn(presetn),
    .start(cal_start),
    .tick(pfd_tick),
    .vco_high(pin_q_r[`PIN_VHI]),
    .busy(sel_busy),
    .code(sel_code)
  );

  // Calibration results and loop release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_code <= 10'h000;
      cal_busy <= 1'b0;
      loop_enable <= 1'b0;
    end else begin
      cal_code <= sel_code;
      cal_busy <= sel_busy;
      loop_enable <= !sel_busy;
    end
  end

  // Test multiplexer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mux_pin <= 1'b0;
    end else begin
      unique case (latch_r[4][`MUX_MSB:`MUX_LSB])
        3'h0: test_mux_pin <= 1'b0;
        3'h1: test_mux_pin <= 1'b1;
        3'h2: test_mux_pin <= pfd_tick;
        3'h3: test_mux_pin <= pin_q_r[`PIN_LOCK];
        3'h4: test_mux_pin <= sel_busy;
        3'h5: test_mux_pin <= int_mode;
        3'h6: test_mux_pin <= pin_q_r[`PIN_REF];
        3'h7: test_mux_pin <= pin_q_r[`PIN_VHI];
      endcase
    end
  end

  // APB: answer one cycle after setup, never waits longer
  assign apb_setup = psel && !penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;

  // Read mux and address check
  always_comb begin
    rd_nxt = `ERR_DATA;
    err_nxt = 1'b0;
    case (paddr)
      `ADDR_CTRL: rd_nxt = {31'h0000_0000, port_en_r};
      `ADDR_STATUS: rd_nxt = {24'h00_0000, rf_out_enable,
                              pin_q_r[`PIN_LOCK], loop_enable,
                              cal_busy, int_mode, out_div_sel};
      `ADDR_RD_SEL: rd_nxt = {28'h000_0000, rd_sel_r};
      `ADDR_RD_DATA: rd_nxt = (rd_sel_r <= `LAST_INDEX) ?
                              latch_r[rd_sel_r] : `ERR_DATA;
      `ADDR_CAL: rd_nxt = {22'h00_0000, cal_code};
      default: err_nxt = 1'b1;
    endcase
  end

  // Registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && err_nxt;
      prdata <= (apb_setup && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_en_r <= 1'(`CTRL_RESET);
      rd_sel_r <= 4'h0;
    end else if (apb_wr && paddr == `ADDR_CTRL) begin
      port_en_r <= pwdata[0];
    end else if (apb_wr && paddr == `ADDR_RD_SEL) begin
      rd_sel_r <= pwdata[3:0];
    end
  end

  AST_SHIFT_IN: assert property (@(posedge pclk) disable iff (!presetn)
    port_en_r && pin_rise[`PIN_SCLK] |=>
    shift_r == {$past(shift_r[30:0]), $past(pin_q_r[`PIN_SDATA])})
    else $error("shift register did not take data bit");
  AST_LOAD_DEST: assert property (@(posedge pclk) disable iff (!presetn)
    latch_we |=> latch_r[$past(dest_select_bits)] == $past(shift_r))
    else $error("latch did not take shifted word");
  AST_BAD_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[`PIN_LOAD] && shift_r[3:0] > 4'hD |-> !latch_we)
    else $error("illegal select code wrote a latch");
  AST_DB_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !reg0_load |=> $stable(fine_fraction) && $stable(ref_count))
    else $error("buffered setting moved without register 0");
  AST_DB_APPLY: assert property (@(posedge pclk) disable iff (!presetn)
    reg0_load |=> fine_fraction[51:28] ==
    $past(latch_r[1][`MAIN_FRACTION_NUMERATOR_MSB:`MAIN_FRACTION_NUMERATOR_LSB]))
    else $error("numerator not applied on register 0");
  AST_ODIV_NOW: assert property (@(posedge pclk) disable iff (!presetn)
    latch_we && dest_select_bits == 4'h6 && !latch_r[4][`DBB_BIT] |=>
    out_div_sel == $past(shift_r[`ODIV_MSB:`ODIV_LSB]))
    else $error("divider select not applied at once");
  AST_INT_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 int_mode == ($past(fine_fraction) == 52'h0))
    else $error("integer mode flag wrong");
  AST_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
    latch_r[6][`MUTE_UNTIL_LOCK_BIT] && !pin_q_r[`PIN_LOCK] |=> !rf_out_enable)
    else $error("output on before lock");
  AST_APB_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready ##1 !pready)
    else $error("APB answer not a single cycle");

endmodule // synth_serial_program_latch
`default_nettype wire

// ---- tb/serial_host_model.sv ----
// Host controller model driving the three-wire programming pins
`timescale 1ns/10ps
`default_nettype none
module serial_host_model #(
  parameter int HOLD = 5 // Pclk cycles per pin level, sync needs 4
) (
  input wire logic pclk,
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  logic framing; // High while a word is on the wire

  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
    framing = 1'b0;
  end

  // Idle data line toggles, so a stale bit is never trusted
  always @(posedge pclk) begin
    if (!framing) begin
      ser_data <= ~ser_data;
    end
  end

  // Wait some rising edges
  task automatic hold_for(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One word MSB first, then the strobe; clock rests low outside frames
  task automatic send_word(input logic [31:0] w);
    @(posedge pclk);
    framing <= 1'b1;
    @(posedge pclk);
    for (int i = 31; i >= 0; i--) begin
      ser_data <= w[i];
      hold_for(HOLD);
      ser_clk <= 1'b1;
      hold_for(HOLD);
      ser_clk <= 1'b0;
    end
    hold_for(HOLD);
    load_strobe <= 1'b1; // Only after the last clock
    hold_for(HOLD);
    load_strobe <= 1'b0;
    framing <= 1'b0;
  endtask
endmodule // serial_host_model
`default_nettype wire

// ---- tb/synth_serial_program_latch_test.sv ----
// Bench for the serial program latch: pins, APB reads and outputs
`timescale 1ns/10ps
`default_nettype none
`include "synth_prog_params.svh"
module synth_serial_program_latch_test
  import synth_prog_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lfsr, w;
  logic ser_clk, ser_data, load_strobe, ref_in, lock_detect, vco_high;
  logic [15:0] int_value;
  logic [51:0] fine_fraction;
  logic [27:0] aux_modulus;
  logic int_mode, ref_doubler, ref_half_divide, rf_out_enable;
  logic test_mux_pin, cal_busy, loop_enable, pfd_tick;
  logic tick_d; // Tick seen one cycle back
  logic [9:0] ref_count;
  logic [3:0] cp_current;
  logic [2:0] out_div_sel, exp_div, ref_ph;
  logic [1:0] rf_power_level;
  logic [7:0] mux_tab; // Expected test pin per select code
  cal_code_t cal_code;
  int errors, total_checks, ticks, n;
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata}, oldest first
  logic [31:0] lat[14]; // Shadow latches
  logic [31:0] app[14]; // Shadow as of the last register-0 load

  synth_serial_program_latch u_synth_serial_program_latch (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ser_clk, .ser_data, .load_strobe, .ref_in,
    .lock_detect, .vco_high, .int_value, .fine_fraction, .aux_modulus,
    .int_mode, .ref_count, .ref_doubler, .ref_half_divide, .cp_current,
    .out_div_sel, .rf_power_level, .rf_out_enable, .test_mux_pin,
    .cal_code, .cal_busy, .loop_enable, .pfd_tick);
  serial_host_model u_serial_host_model (.pclk, .ser_clk, .ser_data,
    .load_strobe);

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Reference 8 cycles a period; ticks counted during a search
  always @(posedge pclk) begin
    ref_ph <= ref_ph + 3'h1;
    ref_in <= ref_ph[2];
    tick_d <= pfd_tick;
    // Busy flag lags the search by one cycle, so pair it with a late tick
    if (cal_busy === 1'b1 && tick_d === 1'b1) ticks <= ticks + 1;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic bad(input string s);
    errors++;
    $display("MISMATCH %0t %s", $time, s);
  endtask

  // A spent wait ends the run
  task automatic fail(input string s);
    bad(s);
    stop_test();
  endtask

  task automatic check_port(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) bad($sformatf("port %h want %h", g, e));
  endtask

  task automatic check_read(input logic [32:0] g, input logic [32:0] e);
    total_checks++;
    if (g !== e) bad($sformatf("read %h want %h", g, e));
  endtask

  // Monitor takes the oldest note at every completed read
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) bad("stray read");
      else check_read({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // APB transfer, held until pready; starts and ends after an edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) fail("no pready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Random word for one select code, fields kept legal
  function automatic logic [31:0] mk(input logic [3:0] idx);
    logic [31:0] v;
    repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v = {lfsr[31:4], idx};
    if (idx == 4'h0) v[31:20] = 12'h000; // Autocal off unless asked
    if (idx == 4'h4) v[24:14] = 11'h007; // Ratio 3, DB14 set
    return v;
  endfunction

  // Send a word and update the shadows
  task automatic load(input logic [31:0] v);
    u_serial_host_model.send_word(v);
    if (v[3:0] <= `LAST_INDEX) lat[v[3:0]] = v;
    if (v[3:0] == 4'h6 && !lat[4][14]) exp_div = v[23:21];
    if (v[3:0] == 4'h0) begin
      app = lat;
      if (lat[4][14]) exp_div = lat[6][23:21];
    end
    repeat (8) @(posedge pclk);
  endtask

  function automatic logic ff_zero();
    return {app[1][27:4], app[13][31:18], app[2][31:18]} == 52'h0;
  endfunction

  task automatic check_applied();
    check_port(int_value, app[0][19:4]);
    check_port(fine_fraction, {app[1][27:4], app[13][31:18],
      app[2][31:18]});
    check_port(aux_modulus, {app[13][17:4], app[2][17:4]});
    check_port(int_mode, ff_zero());
    check_port({ref_doubler, ref_half_divide, cp_current, ref_count},
      {app[4][26:25], app[4][13:10], app[4][24:15]});
    check_port(out_div_sel, exp_div);
    check_port(rf_power_level, lat[6][2:1]);
    check_port(rf_out_enable, !(lat[6][11] && !lock_detect));
  endtask

  // Read every latch back through the select register
  task automatic check_latches();
    for (int i = 0; i < 14; i++) begin
      apb(1'b1, `ADDR_RD_SEL, 32'(i));
      rd(`ADDR_RD_DATA, {1'b0, lat[i]});
    end
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ref_ph = 3'h0;
    ref_in = 1'b0;
    lock_detect = 1'b0;
    vco_high = 1'b0;
    lfsr = 32'h0001_2ACD;
    exp_div = 3'h0;
    ticks = 0;
    errors = 0;
    total_checks = 0;
    foreach (lat[i]) lat[i] = 32'h0000_0000;
    app = lat;
    app[4] = 32'h0000_8000; // Ratio resets to one
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    check_applied();
    rd(`ADDR_CTRL, {1'b0, `CTRL_RESET});
    rd(8'h14, {1'b1, `ERR_DATA}); // Unmapped address
    for (int i = 1; i < 16; i++) load(mk(i[3:0]));
    check_applied(); // Nothing applied yet
    load(mk(4'h0));
    check_latches();
    check_applied();
    check_port(cal_busy, 1'b0);
    w = mk(4'h4);
    w[14] = 1'b0;
    load(w);
    load(mk(4'h6));
    check_applied(); // Divider applies at once
    load(mk(4'h1) & 32'h0000_000F);
    load(mk(4'h2) & 32'h0003_FFFF);
    load(mk(4'hD) & 32'h0003_FFFF);
    load(mk(4'h0));
    check_applied(); // Both numerators zero
    for (int k = 0; k < 2; k++) begin
      w = mk(4'h6);
      w[11] = 1'b1;
      lock_detect <= k[0];
      load(w);
      check_applied();
    end
    vco_high <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      w = mk(4'h4);
      w[29:27] = m[2:0];
      load(w);
      mux_tab = {vco_high, 1'b0, ff_zero(), 1'b0, lock_detect, 3'b010};
      // Tick and reference selections pulse; wait for a high phase
      n = 0;
      while ((m == 2 || m == 6) && test_mux_pin !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      if (m == 2 || m == 6) check_port(test_mux_pin, 1'b1);
      else check_port(test_mux_pin, mux_tab[m]);
    end
    for (int v = 0; v < 2; v++) begin
      vco_high <= v[0];
      ticks = 0;
      w = mk(4'h0);
      w[21] = 1'b1; // Autocal requested
      load(w);
      check_port({cal_busy, loop_enable}, 2'b10);
      n = 0;
      while (cal_busy === 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 2000) fail("search hung");
      repeat (3) @(posedge pclk);
      check_port(ticks, 10); // Steps on divided reference
      check_port({loop_enable, cal_code},
        {1'b1, v ? 10'h000 : 10'h3FF});
      rd(`ADDR_CAL, {23'h000000, v ? 10'h000 : 10'h3FF});
    end
    n = 0;
    while (pfd_tick !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (pfd_tick !== 1'b1) fail("no reference tick");
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pfd_tick !== 1'b1 && n < 100);
    check_port(n, app[4][24:15] * 8); // Tick per ratio rises
    repeat (4) @(posedge pclk);
    if (exp_q.size() != 0) bad("reads left");
    stop_test();
  end
endmodule // synth_serial_program_latch_test
`default_nettype wire
